// [rtl/core_cfg_pkg.sv]
// package: register map, field positions and codes for the core config and address block
package core_cfg_pkg;
   // ****************************************
   // register map (apb byte addresses)
   // ****************************************
   localparam logic [7:0] cfg_off = 8'h00;
   localparam logic [7:0] vtb_off = 8'h04;
   localparam logic [7:0] isp_off = 8'h08;
   localparam logic [7:0] usp_off = 8'h0c;
   localparam logic [7:0] sp_off = 8'h10;
   localparam logic [7:0] mode_off = 8'h14;
   localparam logic [7:0] ea_off = 8'h18;
   localparam logic [7:0] sta_off = 8'h1c;
   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int wide_dispatch_bit = 8;
   localparam int short_reg_bit = 9;
   localparam logic [15:0] cfg_wmask = 16'h0300;
   localparam logic [15:0] cfg_reset = 16'h0000;
   localparam logic [31:0] ptr_mask = 32'h00ff_fffe;
   localparam logic [31:0] usp_limit = 32'h00ff_ffff;
   localparam logic [31:0] low_limit = 32'h0002_0000;
   localparam logic [31:0] frame_bytes = 32'h0000_0004;
   // ****************************************
   // command and address mode codes
   // ****************************************
   typedef enum logic [2:0] {
      op_none, op_push, op_pop, op_pop_and_return,
      op_exc_entry, op_exc_return, op_jump_to_less_privileged, op_load_processor_reg_double
   } stack_op_t;
   typedef enum logic [2:0] {
      am_branch, am_rel_reg, am_rel_pair, am_index_rel, am_index_abs, am_absolute
   } addr_mode_t;
endpackage

// [rtl/core_config_addr_stack.sv]
// core configuration register, operand address generation and stack pointer selection
//
// Function
// - reset clears configuration register entirely
// - wide dispatch bit selects 16/32-bit entries
// - vector table base unaffected by entry size
// - short mode uses low 16 register bits
// - short mode pairs return register, single-register displacement
// - pair low bits in lower register
// - long mode treats base, return, sp as pairs
// - branch target is pc plus displacement
// - relative address never modifies base register
// - index mode only with short bit clear
// - index relative: base plus pair plus displacement
// - index absolute: base plus 20-bit address
// - absolute address comes straight from instruction
// - stacks grow downward
// - exception entry pushes, return pops state
// - only push, pop, pop-return touch program stack
// - supervisor uses supervisor stack pointer
// - user mode uses alternate stack pointer
// - user mode entered by jump instruction, or re-entered by exception return
// - exceptions leave user mode, return restores
// - user mode blocks processor register double load
// - alternate pointer beyond 24 bits traps
// - privilege bit selects pointer and mode
//
// The APB interface to the registers and the address map are this design's own decisions.
module core_config_addr_stack
   import core_cfg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic op_valid,
   input wire stack_op_t op_code,
   input wire logic [31:0] op_target,
   input wire logic [31:0] op_data,
   input wire logic [2:0] op_vector,
   input wire logic ag_valid,
   input wire addr_mode_t ag_mode,
   input wire logic [31:0] ag_pc,
   input wire logic [31:0] ag_reg,
   input wire logic [15:0] ag_pair_low,
   input wire logic [15:0] ag_pair_high,
   input wire logic ag_base_sel,
   input wire logic [31:0] index_base_first,
   input wire logic [31:0] index_base_second,
   input wire logic [31:0] ag_disp,
   input wire logic ag_disp_wide,
   output logic [31:0] ea_q,
   output logic ea_valid_q,
   output logic ea_fault_q,
   output logic [31:0] stack_addr_q,
   output logic stack_write_q,
   output logic stack_valid_q,
   output logic [31:0] dispatch_addr_q,
   output logic illegal_address_trap_q,
   output logic privileged_denied_q,
   output logic privilege_level_bit_q,
   output logic wide_dispatch_select_q,
   output logic short_register_mode_q,
   output logic [31:0] pc_q
);
   // ****************************************
   // register state
   // ****************************************
   logic [15:0] cfg_q;
   logic [31:0] vector_table_base_q;
   logic [31:0] exception_stack_pointer_q;
   logic [31:0] alternate_stack_pointer_q;
   logic [31:0] super_sp_q;
   logic saved_priv_q;
   logic [31:0] ea_d;
   logic ea_fault_d;
   logic wr_en;
   logic rd_en;
   logic [31:0] cur_sp;
   logic usp_bad;
   logic [31:0] pair_val;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pair_val = {ag_pair_high, ag_pair_low};
   assign cur_sp = privilege_level_bit_q ? alternate_stack_pointer_q : super_sp_q;
   assign usp_bad = privilege_level_bit_q && (alternate_stack_pointer_q > usp_limit);

   // ****************************************
   // apb slave answer, zero wait states
   // ****************************************
   logic setup_phase;
   logic addr_hit;
   logic [31:0] rd_mux;
   assign setup_phase = psel && !penable;
   always_comb begin
      rd_mux = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         cfg_off: rd_mux = {16'h0000, cfg_q};
         vtb_off: rd_mux = vector_table_base_q;
         isp_off: rd_mux = exception_stack_pointer_q;
         usp_off: rd_mux = alternate_stack_pointer_q;
         sp_off: rd_mux = super_sp_q;
         mode_off: rd_mux = {31'h0000_0000, privilege_level_bit_q};
         ea_off: rd_mux = ea_q;
         sta_off: rd_mux = {28'h000_0000, ea_fault_q, privileged_denied_q, illegal_address_trap_q, ea_valid_q};
         default: begin
            rd_mux = 32'h0000_0000;
            addr_hit = 1'b0;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_phase;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup_phase && !addr_hit;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata <= rd_mux;
      end else if (!rd_en) begin
         prdata <= 32'h0000_0000;
      end
   end

   // ****************************************
   // configuration register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= cfg_reset;
      end else if (wr_en && pready && paddr == cfg_off) begin
         cfg_q <= pwdata[15:0] & cfg_wmask;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wide_dispatch_select_q <= 1'b0;
         short_register_mode_q <= 1'b0;
      end else begin
         wide_dispatch_select_q <= cfg_q[wide_dispatch_bit];
         short_register_mode_q <= cfg_q[short_reg_bit];
      end
   end

   // ****************************************
   // vector table base and exception pointer
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_table_base_q <= 32'h0000_0000;
      end else if (wr_en && pready && paddr == vtb_off) begin
         vector_table_base_q <= pwdata & ptr_mask;
      end
   end
   logic [31:0] entry_off_narrow;
   logic [31:0] entry_off_wide;
   assign entry_off_narrow = {28'h000_0000, op_vector, 1'b0};
   assign entry_off_wide = {27'h000_0000, op_vector, 2'b00};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dispatch_addr_q <= 32'h0000_0000;
      end else if (op_valid && op_code == op_exc_entry) begin
         if (cfg_q[wide_dispatch_bit]) begin
            dispatch_addr_q <= vector_table_base_q + entry_off_wide;
         end else begin
            dispatch_addr_q <= vector_table_base_q + entry_off_narrow;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exception_stack_pointer_q <= 32'h0000_0000;
      end else if (wr_en && pready && paddr == isp_off) begin
         exception_stack_pointer_q <= pwdata & ptr_mask;
      end else if (op_valid && op_code == op_exc_entry) begin
         exception_stack_pointer_q <= exception_stack_pointer_q - frame_bytes;
      end else if (op_valid && op_code == op_exc_return) begin
         exception_stack_pointer_q <= exception_stack_pointer_q + frame_bytes;
      end
   end

   // ****************************************
   // privilege mode
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         saved_priv_q <= 1'b0;
      end else if (op_valid && op_code == op_exc_entry) begin
         saved_priv_q <= privilege_level_bit_q;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         privilege_level_bit_q <= 1'b0;
      end else if (op_valid) begin
         case (op_code)
            op_jump_to_less_privileged: begin
               privilege_level_bit_q <= 1'b1;
            end
            op_exc_entry: begin
               privilege_level_bit_q <= 1'b0;
            end
            op_exc_return: begin
               privilege_level_bit_q <= saved_priv_q;
            end
            default: begin
               privilege_level_bit_q <= privilege_level_bit_q;
            end
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= 32'h0000_0000;
      end else if (op_valid && op_code == op_jump_to_less_privileged) begin
         pc_q <= op_target & ptr_mask;
      end
   end

   // ****************************************
   // program stack pointers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         super_sp_q <= 32'h0000_0000;
         alternate_stack_pointer_q <= 32'h0000_0000;
         privileged_denied_q <= 1'b0;
      end else begin
         privileged_denied_q <= 1'b0;
         if (wr_en && pready && paddr == sp_off)
            super_sp_q <= pwdata;
         else if (wr_en && pready && paddr == usp_off)
            alternate_stack_pointer_q <= pwdata;
         else if (op_valid && op_code == op_load_processor_reg_double) begin
            if (privilege_level_bit_q)
               privileged_denied_q <= 1'b1;
            else
               alternate_stack_pointer_q <= op_data;
         end else if (op_valid && !usp_bad && op_code inside {op_push, op_pop, op_pop_and_return}) begin
            if (privilege_level_bit_q)
               alternate_stack_pointer_q <= (op_code == op_push) ? cur_sp - frame_bytes
                  : cur_sp + frame_bytes;
            else
               super_sp_q <= (op_code == op_push) ? cur_sp - frame_bytes : cur_sp + frame_bytes;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_addr_q <= 32'h0000_0000;
         stack_write_q <= 1'b0;
         stack_valid_q <= 1'b0;
         illegal_address_trap_q <= 1'b0;
      end else begin
         stack_valid_q <= 1'b0;
         stack_write_q <= 1'b0;
         illegal_address_trap_q <= 1'b0;
         if (op_valid && op_code inside {op_push, op_pop, op_pop_and_return}) begin
            if (usp_bad) begin
               illegal_address_trap_q <= 1'b1;
            end else begin
               stack_valid_q <= 1'b1;
               stack_write_q <= (op_code == op_push);
               stack_addr_q <= (op_code == op_push) ? cur_sp - frame_bytes : cur_sp;
            end
         end else if (op_valid && op_code == op_exc_entry) begin
            stack_valid_q <= 1'b1;
            stack_write_q <= 1'b1;
            stack_addr_q <= exception_stack_pointer_q - frame_bytes;
         end else if (op_valid && op_code == op_exc_return) begin
            stack_valid_q <= 1'b1;
            stack_addr_q <= exception_stack_pointer_q;
         end
      end
   end

   // ****************************************
   // operand address generation
   // ****************************************
   logic [31:0] index_base;
   logic [31:0] short_reg_val;
   logic [31:0] disp_short_rel;
   logic [31:0] disp_index_rel;
   logic [31:0] disp_abs20;
   logic [31:0] disp_abs24;
   logic index_illegal;
   assign index_base = ag_base_sel ? index_base_second : index_base_first;
   assign short_reg_val = {16'h0000, ag_reg[15:0]};
   assign disp_short_rel = ag_disp_wide ? {18'h0_0000, ag_disp[13:0]} : 32'h0000_0000;
   assign disp_index_rel = ag_disp_wide ? {12'h000, ag_disp[19:0]} : {18'h0_0000, ag_disp[13:0]};
   assign disp_abs20 = {12'h000, ag_disp[19:0]};
   assign disp_abs24 = {8'h00, ag_disp[23:0]};
   assign index_illegal = short_register_mode_q;
   always_comb begin
      ea_d = 32'h0000_0000;
      ea_fault_d = 1'b0;
      case (ag_mode)
         am_branch: begin
            ea_d = ag_pc + ag_disp;
         end
         am_rel_reg: begin
            if (short_register_mode_q) begin
               ea_d = short_reg_val + disp_short_rel;
            end else begin
               ea_d = ag_reg + ag_disp;
            end
         end
         am_rel_pair: begin
            ea_d = pair_val + ag_disp;
         end
         am_index_rel: begin
            ea_fault_d = index_illegal;
            ea_d = index_base + pair_val + disp_index_rel;
         end
         am_index_abs: begin
            ea_fault_d = index_illegal;
            ea_d = index_base + disp_abs20;
         end
         am_absolute: begin
            ea_d = ag_disp_wide ? disp_abs24 : disp_abs20;
         end
         default: begin
            ea_fault_d = 1'b1;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ea_valid_q <= 1'b0;
      end else begin
         ea_valid_q <= ag_valid;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ea_q <= 32'h0000_0000;
         ea_fault_q <= 1'b0;
      end else if (ag_valid) begin
         ea_q <= ea_d;
         ea_fault_q <= ea_fault_d;
      end
   end
endmodule

// [sim/core_config_addr_stack_asserts.sv]
// checker: concurrent properties for the core config, address and stack block
module core_config_addr_stack_asserts
   import core_cfg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic op_valid,
   input wire stack_op_t op_code,
   input wire logic [31:0] op_target,
   input wire logic ag_valid,
   input wire addr_mode_t ag_mode,
   input wire logic [31:0] ag_pc,
   input wire logic [31:0] ag_disp,
   input wire logic ag_disp_wide,
   input wire logic [31:0] ea_q,
   input wire logic ea_valid_q,
   input wire logic ea_fault_q,
   input wire logic [31:0] stack_addr_q,
   input wire logic stack_write_q,
   input wire logic stack_valid_q,
   input wire logic privileged_denied_q,
   input wire logic privilege_level_bit_q,
   input wire logic wide_dispatch_select_q,
   input wire logic short_register_mode_q,
   input wire logic [31:0] pc_q
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_two_push;
      op_valid && op_code == op_push && !privilege_level_bit_q ##1 op_valid && op_code == op_push;
   endsequence
   a_reset_clear: assert property ($rose(presetn) |-> !wide_dispatch_select_q && !short_register_mode_q)
      else $error("config outputs not clear after reset");
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_branch_target: assert property (ag_valid && ag_mode == am_branch |=> ea_valid_q && ea_q == $past(ag_pc) + $past(ag_disp))
      else $error("branch target wrong");
   a_absolute_field: assert property (ag_valid && ag_mode == am_absolute |=>
      ea_q == ($past(ag_disp) & ($past(ag_disp_wide) ? 32'h00ff_ffff : 32'h000f_ffff)))
      else $error("absolute address wrong");
   a_index_fault: assert property (ag_valid && short_register_mode_q && ag_mode inside {am_index_rel, am_index_abs} |=> ea_fault_q)
      else $error("index in short mode not flagged");
   a_push_downward: assert property (s_two_push |=> stack_write_q && stack_addr_q == $past(stack_addr_q) - 32'h0000_0004)
      else $error("push did not move down");
   a_none_quiet: assert property (op_valid && op_code == op_none |=> !stack_valid_q)
      else $error("stack touched without stack op");
   a_user_denied: assert property (op_valid && op_code == op_load_processor_reg_double && privilege_level_bit_q |=> privileged_denied_q)
      else $error("double load not denied in user mode");
   a_exc_supervisor: assert property (op_valid && op_code == op_exc_entry |=> !privilege_level_bit_q)
      else $error("exception stayed in user mode");
   a_jump_user: assert property (op_valid && op_code == op_jump_to_less_privileged |=> privilege_level_bit_q && pc_q == $past(op_target))
      else $error("jump did not enter user mode");
endmodule

bind core_config_addr_stack core_config_addr_stack_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready,
   .op_valid, .op_code, .op_target, .ag_valid, .ag_mode, .ag_pc, .ag_disp, .ag_disp_wide, .ea_q, .ea_valid_q,
   .ea_fault_q, .stack_addr_q, .stack_write_q, .stack_valid_q, .privileged_denied_q, .privilege_level_bit_q,
   .wide_dispatch_select_q, .short_register_mode_q, .pc_q);

// [sim/tb_core_config_addr_stack.sv]
// testbench: register access, stack selection, dispatch and address generation
module tb_core_config_addr_stack import core_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, pready, pslverr, ea_valid_q, ea_fault_q, stack_write_q, stack_valid_q, illegal_address_trap_q;
   logic privileged_denied_q, privilege_level_bit_q, wide_dispatch_select_q, short_register_mode_q, err;
   logic presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 0, ag_valid = 0, ag_base_sel = 0, ag_disp_wide = 0;
   logic [7:0] paddr = '0;
   logic [2:0] op_vector = '0;
   logic [15:0] ag_pair_low = '0, ag_pair_high = '0;
   logic [31:0] pwdata = '0, op_target = '0, op_data = '0, ag_pc = '0, ag_reg = '0, ag_disp = '0;
   logic [31:0] index_base_first = '0, index_base_second = '0;
   logic [31:0] prdata, ea_q, stack_addr_q, dispatch_addr_q, pc_q, rd;
   stack_op_t op_code = op_none;
   addr_mode_t ag_mode = am_branch;
   int error_cnt = 0;
   int samples_checked = 0;
   core_config_addr_stack u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .op_valid, .op_code, .op_target, .op_data, .op_vector, .ag_valid, .ag_mode, .ag_pc, .ag_reg,
      .ag_pair_low, .ag_pair_high, .ag_base_sel, .index_base_first, .index_base_second, .ag_disp, .ag_disp_wide,
      .ea_q, .ea_valid_q, .ea_fault_q, .stack_addr_q, .stack_write_q, .stack_valid_q, .dispatch_addr_q,
      .illegal_address_trap_q, .privileged_denied_q, .privilege_level_bit_q, .wide_dispatch_select_q,
      .short_register_mode_q, .pc_q);
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic op(input stack_op_t c, input logic [31:0] t);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= c;
      op_target <= t;
      @(posedge pclk);
      op_valid <= 1'b0;
      #1;
   endtask
   task automatic ag(input addr_mode_t m, input logic s, input logic w, input logic [31:0] d, input logic [31:0] x,
         input logic f);
      @(posedge pclk);
      ag_valid <= 1'b1;
      ag_mode <= m;
      ag_base_sel <= s;
      ag_disp_wide <= w;
      ag_disp <= d;
      @(posedge pclk);
      ag_valid <= 1'b0;
      #1;
      chk(ea_fault_q, f);
      if (!f) chk(ea_q, x);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      apb(0, cfg_off, 0);
      chk(rd, 32'h0000_0000);
      apb(1, cfg_off, 32'hffff_ffff);
      apb(0, cfg_off, 0);
      chk(rd, 32'h0000_0300);
      chk({wide_dispatch_select_q, short_register_mode_q}, 32'h0000_0003);
      apb(0, 8'h20, 0);
      chk(err, 1);
      chk(rd, 32'h0000_0000);
      apb(1, cfg_off, 0);
      $display("register test done");
   endtask
   task automatic t_stack();
      apb(1, sp_off, 32'h0000_1000);
      apb(1, usp_off, 32'h0000_2000);
      apb(1, isp_off, 32'h0000_3000);
      apb(1, vtb_off, 32'h0000_0100);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= op_push;
      op_vector <= 3'd2;
      repeat (2) @(posedge pclk);
      op_valid <= 1'b0;
      #1;
      chk(stack_addr_q, 32'h0000_0ff8);
      op(op_pop, 0);
      chk({stack_write_q, stack_addr_q}, 33'h0_0000_0ff8);
      op(op_none, 0);
      chk(stack_valid_q, 0);
      apb(0, sp_off, 0);
      chk(rd, 32'h0000_0ffc);
      op(op_jump_to_less_privileged, 32'h0000_0400);
      chk({privilege_level_bit_q, pc_q}, 33'h1_0000_0400);
      op(op_push, 0);
      chk(stack_addr_q, 32'h0000_1ffc);
      op(op_load_processor_reg_double, 0);
      chk(privileged_denied_q, 1);
      op(op_exc_entry, 0);
      chk({privilege_level_bit_q, stack_write_q, stack_addr_q}, 34'h1_0000_2ffc);
      chk(dispatch_addr_q, 32'h0000_0104);
      op(op_exc_return, 0);
      chk({privilege_level_bit_q, stack_write_q, stack_addr_q}, 34'h2_0000_2ffc);
      apb(1, usp_off, 32'h0100_0000);
      op(op_pop_and_return, 0);
      chk({illegal_address_trap_q, stack_valid_q}, 32'h0000_0002);
      apb(1, cfg_off, 32'h0000_0100);
      op(op_exc_entry, 0);
      chk(dispatch_addr_q, 32'h0000_0108);
      apb(0, vtb_off, 0);
      chk(rd, 32'h0000_0100);
      $display("stack test done");
   endtask
   task automatic t_addr();
      @(posedge pclk);
      ag_pc <= 32'h0000_1000;
      ag_reg <= 32'h0003_1234;
      ag_pair_low <= 16'h0010;
      ag_pair_high <= 16'h0002;
      index_base_first <= 32'h0005_0000;
      index_base_second <= 32'h0006_0000;
      ag(am_branch, 0, 0, 32'h0000_0020, 32'h0000_1020, 0);
      ag(am_rel_reg, 0, 0, 32'h0000_0010, 32'h0003_1244, 0);
      ag(am_rel_pair, 0, 0, 32'h0000_0004, 32'h0002_0014, 0);
      ag(am_index_rel, 0, 0, 32'h0000_4008, 32'h0007_0018, 0);
      ag(am_index_rel, 1, 1, 32'h0010_0008, 32'h0008_0018, 0);
      ag(am_index_abs, 0, 0, 32'h0012_3456, 32'h0007_3456, 0);
      ag(am_absolute, 0, 0, 32'h0123_4567, 32'h0003_4567, 0);
      ag(am_absolute, 0, 1, 32'h0123_4567, 32'h0023_4567, 0);
      apb(1, cfg_off, 32'h0000_0200);
      ag(am_index_abs, 0, 0, 32'h0000_0000, 32'h0000_0000, 1);
      ag(am_rel_reg, 0, 0, 32'h0000_0010, 32'h0000_1234, 0);
      ag(am_rel_reg, 0, 1, 32'h0000_0010, 32'h0000_1244, 0);
      $display("address test done");
   endtask
   // ****************************************
   // clock and main sequence
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_stack();
      t_addr();
      summarize();
   end
endmodule
